// [src/usart_status_pkg.sv]
/*
 * Constants for the serial channel status, holding and baud timing block.
 * Assumes a 32-bit register port with byte addresses.
 */
package usart_status_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [31:0] OFS_COMMAND    = 32'h40098000;
    localparam logic [31:0] OFS_MODE_CFG   = 32'h40098004;
    localparam logic [31:0] OFS_STATUS     = 32'h40098014;
    localparam logic [31:0] OFS_RX_HOLD    = 32'h40098018;
    localparam logic [31:0] OFS_TX_HOLD    = 32'h4009801C;
    localparam logic [31:0] OFS_BAUD       = 32'h40098020;
    localparam logic [31:0] OFS_IDLE_LIMIT = 32'h40098024;
    localparam logic [31:0] OFS_CHAR_GAP   = 32'h40098028;
    localparam logic [31:0] OFS_CARD_RATIO = 32'h40098040;
    localparam logic [31:0] OFS_CARD_ERR   = 32'h40098044;
    localparam logic [31:0] OFS_LOCK       = 32'h400980E4;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CMD_CLEAR_POS   = 8;
    localparam int CMD_START_TO    = 11;
    localparam int CFG_SYNC_POS    = 8;
    localparam int CFG_OVER_POS    = 19;
    localparam int FRAC_POS        = 16;
    localparam int SYNC_KIND_POS   = 15;
    localparam int ST_RX_READY     = 0;
    localparam int ST_TX_READY     = 1;
    localparam int ST_TIMEOUT      = 8;
    localparam int ST_BREAK        = 13;
    localparam int ST_HEADER       = 14;
    localparam int ST_FRAME_DONE   = 15;
    localparam int ST_FLOW_CHANGE  = 19;
    localparam int ST_LINE_LEVEL   = 23;
    localparam int ST_ERR_LSB      = 24;

    // ------------------------------------------------------------------
    // Reset values and mode codes
    // ------------------------------------------------------------------
    localparam logic [10:0] CARD_RATIO_RST = 11'h174;
    localparam logic [3:0]  MODE_NORMAL    = 4'h0;
    localparam logic [3:0]  MODE_CARD      = 4'h4;
    localparam logic [3:0]  MODE_LIN_MST   = 4'hA;
    localparam logic [3:0]  MODE_LIN_SLV   = 4'hB;
    localparam logic [3:0]  MODE_SPI_MST   = 4'hE;
    localparam logic [3:0]  MODE_SPI_SLV   = 4'hF;
    localparam logic [4:0]  OVER16_TICKS   = 5'h10;
    localparam logic [4:0]  OVER8_TICKS    = 5'h08;

    typedef enum logic [1:0] {
        GAP_OFF = 2'b01,
        GAP_RUN = 2'b10
    } gap_state_t;

endpackage : usart_status_pkg

// [src/usart_status_baud.sv]
/*
 * Channel status flags, receive and transmit holding registers, baud
 * generator with fractional step, receiver time-out, transmitter gap
 * and smart-card error tally for a multi-mode serial channel.
 * Assumes the shifters and LIN engine outside report events as
 * one-cycle pulses synchronous to clk_i.
 */
`timescale 1ns/1ps

// Notes on behaviour
// - Header flag sets on identifier sent or received in LIN modes; sticky.
// - Frame done flag sets when a LIN transfer completes; sticky.
// - Flow input change flag sets on any input edge; status read clears.
// - Outside LIN modes, line level bit mirrors the flow input.
// - In LIN modes the same bit shows the LIN bus level.
// - Biphase error flag sets on decoding error; sticky.
// - Bus bit error flag sets on LIN bit error; sticky.
// - Identifier parity error flag sets on parity error; sticky.
// - Checksum error flag sets on LIN checksum error; sticky.
// - Slave silent error flag sets on no response; sticky.
// - Sync field error flag sets only as LIN slave; sticky.
// - Receive holding returns last character in bits 8 to 0.
// - Bit 15 of receive holding shows command versus data.
// - Transmit sync kind picks command or data delimiter for next character.
// - Divisor zero stops the baud clock; async uses 16 or 8 times divisor.
// - Sync and SPI divide by divisor; card mode by ratio times divisor.
// - Fraction step adds eighths of a cycle to the divisor in async mode only; zero disables.
// - Timing registers ignore writes while the write lock is on.
// - Idle limit zero disables time-out; otherwise limit bit periods.
// - Gap length inserts that many idle bit periods between characters.
// - Card ratio zero gives no bit tick; reset value 0x174.
// - Card error count accumulates errors and clears on read.
// - Break flag sets when a LIN break is sent or received; sticky.
module usart_status_baud #(
    parameter int DIV_W = 16
) (
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic [31:0] addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [31:0] rdata_o,
    input  wire logic        header_evt_i,
    input  wire logic        frame_done_evt_i,
    input  wire logic        break_evt_i,
    input  wire logic        biphase_err_i,
    input  wire logic        bit_err_i,
    input  wire logic        parity_err_i,
    input  wire logic        sum_err_i,
    input  wire logic        silent_err_i,
    input  wire logic        sync_err_i,
    input  wire logic        flow_in_i,
    input  wire logic        bus_line_i,
    input  wire logic        rx_valid_i,
    input  wire logic [8:0]  rx_data_i,
    input  wire logic        rx_cmd_i,
    input  wire logic        rx_line_idle_i,
    input  wire logic        card_err_i,
    input  wire logic        tx_take_i,
    input  wire logic        tx_char_end_i,
    output logic             tx_valid_o,
    output logic      [8:0]  tx_char_o,
    output logic             tx_sync_kind_o,
    output logic             sample_tick_o,
    output logic             bit_tick_o,
    output logic      [3:0]  operating_mode_o
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic is_lin(input logic [3:0] m);
        is_lin = (m == usart_status_pkg::MODE_LIN_MST)
              || (m == usart_status_pkg::MODE_LIN_SLV);
    endfunction : is_lin

    function automatic logic sticky(input logic q, input logic set,
                                    input logic clr);
        sticky = set | (q & ~clr);
    endfunction : sticky

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    logic [31:0]      rdata_r;
    logic [3:0]       mode_r;
    logic             sync_mode_r;
    logic             eightfold_r;
    logic             lock_r;
    logic [DIV_W-1:0] divisor_r;
    logic [2:0]       frac_r;
    logic [16:0]      idle_limit_r;
    logic [7:0]       gap_len_r;
    logic [10:0]      ratio_r;
    logic [7:0]       card_err_r;
    logic [8:0]       rx_char_r;
    logic             rx_kind_r;
    logic             rx_ready_r;
    logic [8:0]       tx_char_r;
    logic             tx_kind_r;
    logic             tx_full_r;
    logic             flow_prev_r;
    logic             flow_chg_r;
    logic             timeout_r;
    logic             to_armed_r;
    logic [16:0]      idle_cnt_r;
    logic [7:0]       gap_cnt_r;
    logic [5:0]       lin_err_r;
    logic             header_r;
    logic             frame_done_r;
    logic             break_r;
    logic [DIV_W-1:0] base_cnt_r;
    logic [2:0]       frac_acc_r;
    logic             frac_extra_r;
    logic [10:0]      bit_cnt_r;
    usart_status_pkg::gap_state_t gap_st_r;

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    wire hit_cmd    = addr_i == usart_status_pkg::OFS_COMMAND;
    wire hit_cfg    = addr_i == usart_status_pkg::OFS_MODE_CFG;
    wire hit_stat   = addr_i == usart_status_pkg::OFS_STATUS;
    wire hit_rx     = addr_i == usart_status_pkg::OFS_RX_HOLD;
    wire hit_tx     = addr_i == usart_status_pkg::OFS_TX_HOLD;
    wire hit_baud   = addr_i == usart_status_pkg::OFS_BAUD;
    wire hit_idle   = addr_i == usart_status_pkg::OFS_IDLE_LIMIT;
    wire hit_gap    = addr_i == usart_status_pkg::OFS_CHAR_GAP;
    wire hit_ratio  = addr_i == usart_status_pkg::OFS_CARD_RATIO;
    wire hit_cerr   = addr_i == usart_status_pkg::OFS_CARD_ERR;
    wire hit_lock   = addr_i == usart_status_pkg::OFS_LOCK;

    wire timing_wr  = wr_i & ~lock_r;
    wire clear_cmd  = wr_i & hit_cmd & wdata_i[usart_status_pkg::CMD_CLEAR_POS];
    wire start_to   = wr_i & hit_cmd & wdata_i[usart_status_pkg::CMD_START_TO];
    wire stat_rd    = rd_i & hit_stat;
    wire rx_rd      = rd_i & hit_rx;
    wire cerr_rd    = rd_i & hit_cerr;
    wire in_lin     = is_lin(mode_r);
    wire in_card    = mode_r == usart_status_pkg::MODE_CARD;
    wire in_spi     = (mode_r == usart_status_pkg::MODE_SPI_MST)
                   || (mode_r == usart_status_pkg::MODE_SPI_SLV);

    // ------------------------------------------------------------------
    // Status word
    // ------------------------------------------------------------------
    wire line_level = in_lin ? bus_line_i : flow_in_i;
    wire flow_edge  = flow_in_i != flow_prev_r;
    wire [5:0] err_evt = {silent_err_i,
                          sum_err_i,
                          parity_err_i,
                          sync_err_i & (mode_r == usart_status_pkg::MODE_LIN_SLV),
                          bit_err_i,
                          biphase_err_i};

    logic [31:0] status_w;
    always_comb begin
        status_w = 32'h00000000;
        status_w[usart_status_pkg::ST_RX_READY]    = rx_ready_r;
        status_w[usart_status_pkg::ST_TX_READY]    = ~tx_full_r;
        status_w[usart_status_pkg::ST_TIMEOUT]     = timeout_r;
        status_w[usart_status_pkg::ST_BREAK]       = break_r;
        status_w[usart_status_pkg::ST_HEADER]      = header_r;
        status_w[usart_status_pkg::ST_FRAME_DONE]  = frame_done_r;
        status_w[usart_status_pkg::ST_FLOW_CHANGE] = flow_chg_r;
        status_w[usart_status_pkg::ST_LINE_LEVEL]  = line_level;
        status_w[usart_status_pkg::ST_ERR_LSB +: 6] = lin_err_r;
    end

    // ------------------------------------------------------------------
    // Read multiplexer
    // ------------------------------------------------------------------
    logic [31:0] rsel_w;
    always_comb begin
        rsel_w = 32'h00000000;
        if (hit_stat) begin
            rsel_w = status_w;
        end else if (hit_cfg) begin
            rsel_w[3:0] = mode_r;
            rsel_w[usart_status_pkg::CFG_SYNC_POS] = sync_mode_r;
            rsel_w[usart_status_pkg::CFG_OVER_POS] = eightfold_r;
        end else if (hit_rx) begin
            rsel_w[8:0] = rx_char_r;
            rsel_w[usart_status_pkg::SYNC_KIND_POS] = rx_kind_r;
        end else if (hit_baud) begin
            rsel_w[DIV_W-1:0] = divisor_r;
            rsel_w[usart_status_pkg::FRAC_POS +: 3] = frac_r;
        end else if (hit_idle) begin
            rsel_w[16:0] = idle_limit_r;
        end else if (hit_gap) begin
            rsel_w[7:0] = gap_len_r;
        end else if (hit_ratio) begin
            rsel_w[10:0] = ratio_r;
        end else if (hit_cerr) begin
            rsel_w[7:0] = card_err_r;
        end else if (hit_lock) begin
            rsel_w[0] = lock_r;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rdata_r <= 32'h00000000;
        end else if (rd_i) begin
            rdata_r <= rsel_w;
        end
    end

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            mode_r       <= usart_status_pkg::MODE_NORMAL;
            sync_mode_r  <= 1'b0;
            eightfold_r  <= 1'b0;
            lock_r       <= 1'b0;
            divisor_r    <= '0;
            frac_r       <= 3'h0;
            idle_limit_r <= 17'h00000;
            gap_len_r    <= 8'h00;
            ratio_r      <= usart_status_pkg::CARD_RATIO_RST;
        end else begin
            if (wr_i & hit_lock) begin
                lock_r <= wdata_i[0];
            end
            if (wr_i & hit_cfg) begin
                mode_r      <= wdata_i[3:0];
                sync_mode_r <= wdata_i[usart_status_pkg::CFG_SYNC_POS];
                eightfold_r <= wdata_i[usart_status_pkg::CFG_OVER_POS];
            end
            if (timing_wr & hit_baud) begin
                divisor_r <= wdata_i[DIV_W-1:0];
                frac_r    <= wdata_i[usart_status_pkg::FRAC_POS +: 3];
            end
            if (timing_wr & hit_idle) begin
                idle_limit_r <= wdata_i[16:0];
            end
            if (timing_wr & hit_gap) begin
                gap_len_r <= wdata_i[7:0];
            end
            if (timing_wr & hit_ratio) begin
                ratio_r <= wdata_i[10:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Sticky status flags
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            lin_err_r    <= 6'h00;
            header_r     <= 1'b0;
            frame_done_r <= 1'b0;
            break_r      <= 1'b0;
            flow_prev_r  <= 1'b0;
            flow_chg_r   <= 1'b0;
        end else begin
            lin_err_r    <= err_evt | (lin_err_r & ~{6{clear_cmd}});
            header_r     <= sticky(header_r, header_evt_i & in_lin,
                                   clear_cmd);
            frame_done_r <= sticky(frame_done_r, frame_done_evt_i,
                                   clear_cmd);
            break_r      <= sticky(break_r, break_evt_i & in_lin,
                                   clear_cmd);
            flow_prev_r  <= flow_in_i;
            flow_chg_r   <= sticky(flow_chg_r, flow_edge, stat_rd);
        end
    end

    // ------------------------------------------------------------------
    // Receive holding and card error tally
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rx_char_r  <= 9'h000;
            rx_kind_r  <= 1'b0;
            rx_ready_r <= 1'b0;
            card_err_r <= 8'h00;
        end else begin
            if (rx_valid_i) begin
                rx_char_r <= rx_data_i;
                rx_kind_r <= rx_cmd_i;
            end
            rx_ready_r <= sticky(rx_ready_r, rx_valid_i, rx_rd);
            if (cerr_rd) begin
                card_err_r <= {7'h00, card_err_i};
            end else if (card_err_i && card_err_r != 8'hFF) begin
                card_err_r <= card_err_r + 8'h01;
            end
        end
    end

    // ------------------------------------------------------------------
    // Transmit holding and character gap
    // ------------------------------------------------------------------
    wire tx_load = wr_i & hit_tx;
    wire gap_done = gap_cnt_r == gap_len_r;

    usart_status_pkg::gap_state_t gap_st_nxt;
    always_comb begin
        gap_st_nxt = gap_st_r;
        unique case (gap_st_r)
            usart_status_pkg::GAP_OFF: begin
                if (tx_char_end_i && gap_len_r != 8'h00) begin
                    gap_st_nxt = usart_status_pkg::GAP_RUN;
                end
            end
            usart_status_pkg::GAP_RUN: begin
                if (bit_tick_o && gap_cnt_r + 8'h01 >= gap_len_r) begin
                    gap_st_nxt = usart_status_pkg::GAP_OFF;
                end
            end
            default: gap_st_nxt = usart_status_pkg::GAP_OFF;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            tx_char_r <= 9'h000;
            tx_kind_r <= 1'b0;
            tx_full_r <= 1'b0;
            gap_st_r  <= usart_status_pkg::GAP_OFF;
            gap_cnt_r <= 8'h00;
        end else begin
            if (tx_load) begin
                tx_char_r <= wdata_i[8:0];
                tx_kind_r <= wdata_i[usart_status_pkg::SYNC_KIND_POS];
            end
            tx_full_r <= tx_load | (tx_full_r & ~tx_take_i);
            gap_st_r  <= gap_st_nxt;
            if (gap_st_r == usart_status_pkg::GAP_OFF || gap_done) begin
                gap_cnt_r <= 8'h00;
            end else if (bit_tick_o) begin
                gap_cnt_r <= gap_cnt_r + 8'h01;
            end
        end
    end

    // ------------------------------------------------------------------
    // Baud generator
    // ------------------------------------------------------------------
    wire [DIV_W-1:0] one_d = {{(DIV_W-1){1'b0}}, 1'b1};
    wire base_end  = (divisor_r != '0)
                   && (base_cnt_r == divisor_r - one_d)
                   && !frac_extra_r;
    wire [3:0] frac_sum = {1'b0, frac_acc_r} + {1'b0, frac_r};
    wire async_m   = !sync_mode_r && !in_spi && !in_card;
    wire [10:0] bit_len = in_card ? ratio_r
                        : {6'h00, eightfold_r ? usart_status_pkg::OVER8_TICKS
                                              : usart_status_pkg::OVER16_TICKS};
    wire bit_end   = async_m || in_card
                   ? base_end && bit_len != 11'h000
                     && bit_cnt_r == bit_len - 11'h001
                   : base_end;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            base_cnt_r   <= '0;
            frac_acc_r   <= 3'h0;
            frac_extra_r <= 1'b0;
            bit_cnt_r    <= 11'h000;
        end else if (divisor_r == '0) begin
            base_cnt_r   <= '0;
            frac_extra_r <= 1'b0;
            bit_cnt_r    <= 11'h000;
        end else if (frac_extra_r) begin
            frac_extra_r <= 1'b0;
        end else if (base_end) begin
            base_cnt_r   <= '0;
            frac_acc_r   <= frac_sum[2:0];
            frac_extra_r <= async_m & frac_sum[3];
            bit_cnt_r    <= bit_end ? 11'h000 : bit_cnt_r + 11'h001;
        end else begin
            base_cnt_r <= base_cnt_r + one_d;
        end
    end

    // ------------------------------------------------------------------
    // Receiver time-out
    // ------------------------------------------------------------------
    wire to_hit = to_armed_r && bit_end && rx_line_idle_i
               && idle_cnt_r + 17'h00001 >= idle_limit_r;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            idle_cnt_r <= 17'h00000;
            to_armed_r <= 1'b0;
            timeout_r  <= 1'b0;
        end else begin
            timeout_r <= to_hit | (timeout_r & ~start_to);
            if (start_to) begin
                to_armed_r <= idle_limit_r != 17'h00000;
                idle_cnt_r <= 17'h00000;
            end else if (to_hit || idle_limit_r == 17'h00000) begin
                to_armed_r <= 1'b0;
                idle_cnt_r <= 17'h00000;
            end else if (!rx_line_idle_i) begin
                idle_cnt_r <= 17'h00000;
            end else if (to_armed_r && bit_end) begin
                idle_cnt_r <= idle_cnt_r + 17'h00001;
            end
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign rdata_o          = rdata_r;
    assign tx_valid_o       = tx_full_r
                            && gap_st_r == usart_status_pkg::GAP_OFF;
    assign tx_char_o        = tx_char_r;
    assign tx_sync_kind_o   = tx_kind_r;
    assign sample_tick_o    = base_end;
    assign bit_tick_o       = bit_end;
    assign operating_mode_o = mode_r;

endmodule : usart_status_baud

// [bench/line_node.sv]
/* Model of the remote node that drains the transmit holding register.
   Assumes the block clock and its synchronous active-high reset. */
`timescale 1ns/1ps
module line_node (
    input  wire logic clk_i,
    input  wire logic sys_rst_i,
    input  wire logic tx_valid_i,
    output logic      tx_take_o,
    output logic      tx_end_o
);
    logic [3:0] busy_r;
    always_ff @(posedge clk_i) begin
        tx_take_o <= 1'h0;
        tx_end_o  <= busy_r == 4'h1;
        if (sys_rst_i) begin
            busy_r <= 4'h0;
        end else if (busy_r != 4'h0) begin
            busy_r <= busy_r - 4'h1;
        end else if (tx_valid_i) begin
            tx_take_o <= 1'h1;
            busy_r    <= 4'h6;
        end
    end
endmodule : line_node

// [bench/usart_status_asserts.sv]
/* Concurrent checks on the register port of the status block.
   Assumes it is bound into usart_status_baud. */
`timescale 1ns/1ps
module usart_status_asserts (
    input wire logic        clk_i,
    input wire logic        sys_rst_i,
    input wire logic [31:0] addr_i,
    input wire logic        wr_i,
    input wire logic        rd_i,
    input wire logic [31:0] rdata_o,
    input wire logic        header_evt_i,
    input wire logic        flow_in_i,
    input wire logic        bus_line_i,
    input wire logic        rx_valid_i,
    input wire logic [8:0]  rx_data_i,
    input wire logic        rx_cmd_i,
    input wire logic        card_err_i,
    input wire logic        tx_take_i,
    input wire logic        tx_valid_o,
    input wire logic [3:0]  operating_mode_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    wire st_rd = rd_i && addr_i == usart_status_pkg::OFS_STATUS;
    wire ne_rd = rd_i && addr_i == usart_status_pkg::OFS_CARD_ERR;
    wire rx_rd = rd_i && addr_i == usart_status_pkg::OFS_RX_HOLD;
    wire lin   = operating_mode_o[3:1] == 3'h5;
    sequence st_twice;
        st_rd ##1 !wr_i && !rd_i ##1 st_rd;
    endsequence
    sequence rx_then_rd;
        rx_valid_i ##1 !rx_valid_i ##1 rx_rd && !rx_valid_i;
    endsequence
    sequence ne_twice;
        ne_rd && !card_err_i ##1 !card_err_i ##1 ne_rd && !card_err_i;
    endsequence
    AST_LVL_FLOW: assert property (st_rd && !lin |=> rdata_o[23] == $past(flow_in_i))
        else $error("level bit differs from flow input");
    AST_LVL_LIN: assert property (st_rd && lin |=> rdata_o[23] == $past(bus_line_i))
        else $error("level bit differs from bus line");
    AST_HEADER: assert property (header_evt_i && lin ##1 !wr_i ##1 st_rd |=> rdata_o[14])
        else $error("header flag not set");
    AST_STICKY: assert property (st_twice |=>
        ($past(rdata_o) & ~rdata_o & 32'h3F00E000) == 0)
        else $error("sticky flag lost on status read");
    AST_CARD_RC: assert property (ne_twice |=> rdata_o == 32'h0)
        else $error("error count not cleared by read");
    AST_CARD_HI: assert property (ne_rd |=> rdata_o[31:8] == 24'h0)
        else $error("unused error count bits set");
    AST_RX_HOLD: assert property (rx_then_rd |=>
        rdata_o == {16'h0, $past(rx_cmd_i, 3), 6'h0, $past(rx_data_i, 3)})
        else $error("receive holding word wrong");
    AST_TX_TAKE: assert property (tx_take_i && !wr_i |=> !tx_valid_o)
        else $error("holding still valid after take");
endmodule : usart_status_asserts
bind usart_status_baud usart_status_asserts CHK (.*);

// [bench/usart_status_baud_bench.sv]
/* Self-checking bench for usart_status_baud with a line node model.
   Assumes the package, design, line_node and checker are compiled first. */
`timescale 1ns/1ps
module usart_status_baud_bench;
    localparam logic [31:0] STA = usart_status_pkg::OFS_STATUS;
    localparam logic [31:0] MOD = usart_status_pkg::OFS_MODE_CFG;
    localparam logic [31:0] SM = 32'h3F00E000;
    localparam logic [31:0] TR [4] = '{usart_status_pkg::OFS_BAUD,
        usart_status_pkg::OFS_IDLE_LIMIT, usart_status_pkg::OFS_CHAR_GAP,
        usart_status_pkg::OFS_CARD_RATIO};
    localparam logic [31:0] TM [4] = '{32'h0007FFFF, 32'h0001FFFF, 32'h000000FF, 32'h000007FF};
    logic        clk_i, sys_rst_i, wr_i, rd_i, flow_in_i, bus_line_i, rx_cmd_i;
    logic        tx_take_i, tx_char_end_i, tx_valid_o, tx_sync_kind_o, bit_tick_o;
    logic [8:0]  rx_data_i, tx_char_o;
    logic [10:0] ev;
    logic [31:0] addr_i, wdata_i, rdata_o, d, v;
    int          n_fail, check_count, n;
    usart_status_baud DUT (.*, .rx_line_idle_i(1'h0), .sample_tick_o(),
        .operating_mode_o(), .header_evt_i(ev[0]), .frame_done_evt_i(ev[1]),
        .break_evt_i(ev[2]), .biphase_err_i(ev[3]), .bit_err_i(ev[4]), .sync_err_i(ev[5]),
        .parity_err_i(ev[6]), .sum_err_i(ev[7]), .silent_err_i(ev[8]),
        .rx_valid_i(ev[9]), .card_err_i(ev[10]));
    line_node PEER (.clk_i, .sys_rst_i, .tx_valid_i(tx_valid_o), .tx_take_o(tx_take_i),
        .tx_end_o(tx_char_end_i));
    task automatic wr(input logic [31:0] a, input logic [31:0] w);
        @(posedge clk_i);
        {wr_i, addr_i, wdata_i} <= {1'h1, a, w};
        @(posedge clk_i);
        wr_i <= 1'h0;
    endtask : wr
    task automatic rd(input logic [31:0] a);
        @(posedge clk_i);
        {rd_i, addr_i} <= {1'h1, a};
        @(posedge clk_i);
        rd_i <= 1'h0;
        #1 d = rdata_o;
    endtask : rd
    task automatic pulse(input int i);
        @(posedge clk_i);
        ev[i] <= 1'h1;
        @(posedge clk_i);
        ev[i] <= 1'h0;
    endtask : pulse
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : report_and_stop
    initial begin
        clk_i = 1'h0;
        forever #2 clk_i = ~clk_i;
    end
    initial begin
        {sys_rst_i, wr_i, rd_i, flow_in_i, bus_line_i, rx_cmd_i} = 6'h22;
        {ev, rx_data_i, addr_i, wdata_i} = '0;
        {n_fail, check_count} = '0;
        void'($urandom(91922));
        repeat (6) @(posedge clk_i);
        sys_rst_i <= 1'h0;
        rd(usart_status_pkg::OFS_CARD_RATIO);
        chk("ratio", 32'h174, d);
        for (int i = 0; i < 4; i++) begin
            v = $urandom();
            wr(TR[i], v);
            rd(TR[i]);
            chk("timing", v & TM[i], d);
            wr(usart_status_pkg::OFS_LOCK, 32'h1);
            wr(TR[i], ~v);
            rd(TR[i]);
            chk("locked", v & TM[i], d);
            wr(usart_status_pkg::OFS_LOCK, 32'h0);
        end
        wr(MOD, 32'hA);
        for (int i = 8; i >= 0; i--) pulse(i);
        rd(STA);
        chk("sticky", 32'h3B00E000, d & SM);
        rd(STA);
        chk("sticky", 32'h3B00E000, d & SM);
        wr(MOD, 32'hB);
        pulse(5);
        rd(STA);
        chk("syncerr", SM, d & SM);
        wr(usart_status_pkg::OFS_COMMAND, 32'h100);
        rd(STA);
        chk("cleared", 32'h0, d & SM);
        wr(MOD, 32'h0);
        flow_in_i <= 1'h1;
        repeat (4) @(posedge clk_i);
        rd(STA);
        chk("flow", 32'h00880000, d & 32'h00880000);
        rd(STA);
        chk("flow", 32'h00800000, d & 32'h00880000);
        wr(MOD, 32'hA);
        bus_line_i <= 1'h0;
        repeat (4) @(posedge clk_i);
        rd(STA);
        chk("level", 32'h0, d & 32'h00800000);
        v = $urandom();
        @(posedge clk_i);
        {rx_cmd_i, rx_data_i} <= {v[15], v[8:0]};
        pulse(9);
        rd(usart_status_pkg::OFS_RX_HOLD);
        chk("rxhold", v & 32'h81FF, d);
        n = $urandom_range(6, 1);
        repeat (n) pulse(10);
        rd(usart_status_pkg::OFS_CARD_ERR);
        chk("errcount", 32'(n), d);
        rd(usart_status_pkg::OFS_CARD_ERR);
        chk("errcount", 32'h0, d);
        wr(usart_status_pkg::OFS_TX_HOLD, v);
        #1 chk("txhold", (v & 32'h81FF) | 32'h10000,
            {15'h0, tx_valid_o, tx_sync_kind_o, 6'h0, tx_char_o});
        for (n = 0; n < 20 && tx_valid_o !== 1'h0; n++) @(posedge clk_i);
        chk("txdrain", 32'h0, {31'h0, tx_valid_o});
        wr(usart_status_pkg::OFS_BAUD, 32'h0);
        wr(usart_status_pkg::OFS_BAUD, 32'h3);
        for (n = 0; n < 99 && bit_tick_o !== 1'h1; n++) @(posedge clk_i);
        @(posedge clk_i);
        for (n = 1; n < 99 && bit_tick_o !== 1'h1; n++) @(posedge clk_i);
        chk("bitper", 32'h30, 32'(n));
        report_and_stop();
    end
endmodule : usart_status_baud_bench
